//--- rtl/fault_monitor_pkg.sv
// constants, encodings and state types shared by the fault monitor design
// assumes a single 10 MHz core clock; fault words are 32 bits, bit k is fault id k+1
package fault_monitor_pkg;
   // core clock rate and the figures derived from it
   localparam int unsigned CLK_FREQ_HZ = 10_000_000;
   localparam int unsigned CYCLES_PER_MS = CLK_FREQ_HZ / 1000;
   localparam int unsigned CHECK_PERIOD_MS = 50; // running check period
   localparam int unsigned CHECK_CYCLES = CHECK_PERIOD_MS * CYCLES_PER_MS;
   localparam int unsigned REBOOT_REGULAR_MS = 130; // regular recovery timeout
   localparam int unsigned REBOOT_REGULAR_CYCLES = REBOOT_REGULAR_MS * CYCLES_PER_MS;
   localparam int unsigned REBOOT_FAST_MS = 0; // fast recovery timeout
   localparam int unsigned REBOOT_FAST_RAW = REBOOT_FAST_MS * CYCLES_PER_MS;
   localparam int unsigned REBOOT_FAST_CYCLES = (REBOOT_FAST_RAW < 1) ? 1 : REBOOT_FAST_RAW;
   // widths
   localparam int NUM_FAULTS = 32;
   localparam int FIDX_W = 5;
   localparam int THRESH_W = 4;
   localparam int TICK_W = 20;
   localparam int REBOOT_W = 22;
   localparam int SLOTS = 4;
   localparam int SLOT_W = 3;
   localparam int CNT_W = 4;
   localparam int ID_W = 8;
   localparam int REG_ADDR_W = 8;
   localparam int NVM_ADDR_W = 6;
   // register and nonvolatile word offsets
   localparam logic [REG_ADDR_W-1:0] FAULT_STATUS_OFFSET = 8'hBC;
   localparam logic [NVM_ADDR_W-1:0] NVM_ADDR_ID = 6'h1C;
   localparam logic [NVM_ADDR_W-1:0] NVM_ADDR_NUM = 6'h1D;
   localparam logic [NVM_ADDR_W-1:0] NVM_ADDR_STATE = 6'h1E;
   // reset values and limits
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
   localparam logic [ID_W-1:0] ID_BASE = 8'h01;
   // fault classes by bit position
   localparam logic [31:0] DEMAND_CHECK_MASK = 32'h0001_5000; // startup or on request
   localparam logic [31:0] ONE_TIME_MASK = 32'h0200_0000; // confirmed on first sighting
   localparam logic [31:0] SENSOR_FAULT_MASK = 32'h3C00_0000; // reported as sensor error
   // state types
   typedef enum logic [1:0] {HW_RUN, HW_WAIT, HW_DONE} hw_state_e;
   typedef enum logic {LOG_IDLE, LOG_WRITE} log_state_e;
endpackage : fault_monitor_pkg

//--- rtl/fault_debounce.sv
// per-fault consecutive-occurrence filter, one counter per fault bit
// assumes tick_i is a one-cycle pulse from the check period divider
`timescale 1ns/1ps
module fault_debounce
   import fault_monitor_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // check control
   input wire logic tick_i,
   input wire logic [NUM_FAULTS-1:0] check_i,
   input wire logic [NUM_FAULTS-1:0] present_i,
   input wire logic [NUM_FAULTS-1:0] one_time_i,
   input wire logic [THRESH_W-1:0] threshold_i,
   // results
   output logic [NUM_FAULTS-1:0] confirmed_o,
   output logic [NUM_FAULTS-1:0] detect_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   // a threshold of zero would confirm a fault that never appeared, so it acts as one
   wire [THRESH_W-1:0] eff_n = (threshold_i == '0) ? 4'h1 : threshold_i;

   genvar g;
   generate
      for (g = 0; g < NUM_FAULTS; g++) begin : g_flt
         logic [THRESH_W-1:0] cnt; // consecutive sightings, saturates at the limit
         logic conf_q; // confirmed level of last cycle
         wire [THRESH_W-1:0] lim = one_time_i[g] ? 4'h1 : eff_n;
         wire hit = tick_i & check_i[g];
         wire [THRESH_W-1:0] next_cnt = !hit ? cnt :
                                        !present_i[g] ? '0 : // R17
                                        (cnt < lim) ? cnt + 4'h1 : cnt; // R6
         assign confirmed_o[g] = (cnt >= lim); // R6
         assign detect_o[g] = confirmed_o[g] & ~conf_q;

         // counter advances only on a check tick for this fault
         always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               cnt <= '0;
               conf_q <= 1'b0;
            end else begin
               cnt <= next_cnt;
               conf_q <= confirmed_o[g];
            end
         end

         a_clear_on_absent: assert property ( // R17
            hit && !present_i[g] |=> cnt == '0)
            else $error("counter not cleared after a clean check");
         a_detect_after_tick: assert property ( // R6
            detect_o[g] |-> $past(hit) && $past(present_i[g]) && cnt == $past(lim))
            else $error("fault confirmed without a qualifying check");
      end
   endgenerate
endmodule : fault_debounce

//--- rtl/fault_monitor_filter_logger.sv
// fault supervision: enables, check tick, debounce, flags, status readback, nvm log
// assumes detectors, nvm cache and lin stack run on core_clk_i; nvm_ack_i answers nvm_req_o
// What this block does
// R1: only faults with enable bit set are seen
// R2: detected fault raises global or sensor flag
// R3: detected fault sets its status register bit
// R4: flags to master, status readable at 0xBC
// R5: running faults checked every 50 ms
// R6: confirm after N consecutive checked occurrences
// R7: logging sets fault bit in logged state word
// R8: first four faults get identifier and count
// R9: count saturates at 15, then no writes
// R10: later faults set state bit only once
// R11: software logs only in qualification, above 5.1 V; not gated here, every log-enabled detection is logged
// R12: hardware fault halts, idles lin, logs, reboots
// R13: software faults set flag, status, log
// R14: reboot wait 130 ms regular, none fast
// R15: self check request reruns startup checks
// R16: watchdog fault accepted at startup and running
// R17: a clean check clears the occurrence counter
// R18: log slots assigned in order, then fixed
`timescale 1ns/1ps
module fault_monitor_filter_logger
   import fault_monitor_pkg::*;
#(
   parameter int unsigned CHECK_PERIOD_CYCLES = CHECK_CYCLES,
   parameter int unsigned REBOOT_PERIOD_CYCLES = REBOOT_REGULAR_CYCLES
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // nonvolatile configuration words
   input wire logic [NUM_FAULTS-1:0] fault_enable_mask_i,
   input wire logic [NUM_FAULTS-1:0] log_enable_mask_i,
   input wire logic [THRESH_W-1:0] consecutive_count_threshold_i,
   input wire logic fast_recovery_i,
   // fault detectors
   input wire logic [NUM_FAULTS-1:0] fault_raw_i,
   input wire logic hw_fault_i,
   input wire logic [FIDX_W-1:0] hw_fault_index_i,
   // lin side
   input wire logic self_check_request_i,
   input wire logic reg_rd_i,
   input wire logic [REG_ADDR_W-1:0] reg_addr_i,
   output logic [31:0] reg_rdata_o,
   output logic global_fault_flag_o,
   output logic sensor_error_flag_o,
   output logic lin_idle_o,
   // processor control
   output logic halt_o,
   output logic reboot_o,
   // nonvolatile write engine
   output logic nvm_req_o,
   output logic [NVM_ADDR_W-1:0] nvm_addr_o,
   output logic [31:0] nvm_data_o,
   input wire logic nvm_ack_i
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   // one-hot decode of a fault index
   function automatic logic [NUM_FAULTS-1:0] onehot(input logic [FIDX_W-1:0] idx);
      onehot = 32'h0000_0001 << idx;
   endfunction : onehot

   // lowest set bit of a fault word, lowest id wins
   function automatic logic [FIDX_W-1:0] first_set(input logic [NUM_FAULTS-1:0] v);
      first_set = '0;
      for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
         if (v[i]) first_set = FIDX_W'(i);
      end
   endfunction : first_set

   hw_state_e hw_state; // processor supervision state
   log_state_e log_state; // logging sequencer state
   logic [TICK_W-1:0] tick_cnt; // check period divider
   logic tick; // one-cycle check enable
   logic demand_arm; // next tick also runs the startup-class checks
   logic [REBOOT_W-1:0] reboot_cnt; // remaining recovery wait
   logic [NUM_FAULTS-1:0] hw_status; // latched hardware fault bit
   logic [NUM_FAULTS-1:0] fault_status; // readback word
   logic [NUM_FAULTS-1:0] pending; // detections waiting to be logged
   logic [NUM_FAULTS-1:0] logged_state; // shadow of the logged state word
   logic [FIDX_W-1:0] slot_id [SLOTS]; // fault index held by each slot
   logic [CNT_W-1:0] slot_cnt [SLOTS]; // occurrence count per slot
   logic [SLOT_W-1:0] slots_used; // slots taken so far
   logic [2:0] wr_todo; // {count word, id word, state word} still to write
   logic [NUM_FAULTS-1:0] confirmed; // debounced fault levels
   logic [NUM_FAULTS-1:0] detect; // one-cycle confirmation events

   // check tick, frozen while the processor is halted
   wire running = (hw_state == HW_RUN);
   wire tick_wrap = (tick_cnt == TICK_W'(CHECK_PERIOD_CYCLES - 1));
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= running & tick_wrap; // R5
         tick_cnt <= (tick_wrap || !running) ? '0 : tick_cnt + TICK_W'(1);
      end
   end

   // startup-class checks: armed out of reset and on request; a request wins over the clear
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) demand_arm <= 1'b1;
      else demand_arm <= self_check_request_i | (demand_arm & ~tick); // R15
   end

   // only enabled faults reach the filter
   wire [NUM_FAULTS-1:0] present = fault_raw_i & fault_enable_mask_i; // R1
   wire [NUM_FAULTS-1:0] check_vec = ~DEMAND_CHECK_MASK | {NUM_FAULTS{demand_arm}}; // R15

   fault_debounce u_debounce (
      .core_clk_i (core_clk_i),
      .sys_rst_i (sys_rst_i),
      .tick_i (tick),
      .check_i (check_vec),
      .present_i (present),
      .one_time_i (ONE_TIME_MASK | DEMAND_CHECK_MASK),
      .threshold_i (consecutive_count_threshold_i),
      .confirmed_o (confirmed),
      .detect_o (detect)
   );

   // hardware-class faults, watchdog included, are taken whenever the processor runs
   wire hw_take = hw_fault_i & fault_enable_mask_i[hw_fault_index_i] & running; // R16
   wire [REBOOT_W-1:0] reboot_load = fast_recovery_i ? REBOOT_W'(REBOOT_FAST_CYCLES - 1)
                                                     : REBOOT_W'(REBOOT_PERIOD_CYCLES - 1);
   wire log_busy = (log_state != LOG_IDLE) || (pending != '0);

   // halt, idle lin, wait out the recovery time, then reboot once logging is done
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hw_state <= HW_RUN;
         reboot_cnt <= '0;
         halt_o <= 1'b0;
         lin_idle_o <= 1'b0;
         reboot_o <= 1'b0;
         hw_status <= '0;
      end else begin
         reboot_o <= 1'b0;
         case (hw_state)
            HW_RUN: if (hw_take) begin
               hw_state <= HW_WAIT;
               halt_o <= 1'b1; // R12
               lin_idle_o <= 1'b1; // R12
               hw_status <= onehot(hw_fault_index_i);
               reboot_cnt <= reboot_load; // R14
            end
            HW_WAIT: if (reboot_cnt != '0) begin
               reboot_cnt <= reboot_cnt - REBOOT_W'(1);
            end else if (!log_busy) begin
               reboot_o <= 1'b1; // R12
               hw_state <= HW_DONE;
            end
            HW_DONE: ; // held until the reboot resets the block
            default: hw_state <= HW_RUN;
         endcase
      end
   end

   // flags and status readback word
   wire [NUM_FAULTS-1:0] next_status = (confirmed & fault_enable_mask_i) | hw_status; // R3
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fault_status <= STATUS_RESET;
         global_fault_flag_o <= 1'b0;
         sensor_error_flag_o <= 1'b0;
         reg_rdata_o <= '0;
      end else begin
         fault_status <= next_status; // R13
         global_fault_flag_o <= |(fault_status & ~SENSOR_FAULT_MASK); // R2
         sensor_error_flag_o <= |(fault_status & SENSOR_FAULT_MASK); // R2
         // unmatched addresses read zero, other registers live elsewhere
         reg_rdata_o <= (reg_rd_i && reg_addr_i == FAULT_STATUS_OFFSET) ? fault_status : '0; // R4
      end
   end

   // logging: one detection is taken at a time, lowest fault id first
   wire [NUM_FAULTS-1:0] hw_log = (hw_take && log_enable_mask_i[hw_fault_index_i]) ?
                                  onehot(hw_fault_index_i) : '0;
   wire [NUM_FAULTS-1:0] new_log = (detect & log_enable_mask_i) | hw_log; // R7
   wire pick_valid = (log_state == LOG_IDLE) && (pending != '0);
   wire [FIDX_W-1:0] pick_idx = first_set(pending);
   wire [NUM_FAULTS-1:0] pick_oh = pick_valid ? onehot(pick_idx) : '0;

   logic [SLOTS-1:0] slot_hit; // slot already holding the picked fault
   logic [CNT_W-1:0] hit_cnt; // its count
   logic [ID_W*SLOTS-1:0] id_word; // packed identifier word
   logic [CNT_W*SLOTS-1:0] num_word; // packed count word
   wire any_hit = |slot_hit;
   wire new_slot = !any_hit && (slots_used < SLOT_W'(SLOTS)); // R18
   wire w_num = new_slot | (any_hit & (hit_cnt != CNT_MAX)); // R9
   wire w_state = ~logged_state[pick_idx]; // R10

   always_comb begin
      hit_cnt = '0;
      for (int k = 0; k < SLOTS; k++) begin
         if (slot_hit[k]) hit_cnt = slot_cnt[k];
      end
   end

   genvar s;
   generate
      for (s = 0; s < SLOTS; s++) begin : g_slot
         wire used = (SLOT_W'(s) < slots_used);
         assign slot_hit[s] = used && (slot_id[s] == pick_idx);
         assign id_word[s*ID_W +: ID_W] = used ? ID_W'(slot_id[s]) + ID_BASE : '0; // R8
         assign num_word[s*CNT_W +: CNT_W] = slot_cnt[s];
         // a slot is written once on assignment, after that only its count moves
         always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               slot_id[s] <= '0;
               slot_cnt[s] <= '0;
            end else if (pick_valid && new_slot && slots_used == SLOT_W'(s)) begin
               slot_id[s] <= pick_idx; // R18
               slot_cnt[s] <= CNT_W'(1); // R8
            end else if (pick_valid && slot_hit[s] && slot_cnt[s] != CNT_MAX) begin
               slot_cnt[s] <= slot_cnt[s] + CNT_W'(1); // R9
            end
         end
      end
   endgenerate

   // write order: state word, then identifier word, then count word
   wire [NVM_ADDR_W-1:0] sel_addr = wr_todo[0] ? NVM_ADDR_STATE :
                                    wr_todo[1] ? NVM_ADDR_ID : NVM_ADDR_NUM;
   wire [31:0] sel_data = wr_todo[0] ? logged_state :
                          wr_todo[1] ? id_word : {16'h0000, num_word};
   wire [2:0] cur_bit = wr_todo & (~wr_todo + 3'h1);

   // new detections pend; a detection in the cycle it is picked is kept
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         log_state <= LOG_IDLE;
         pending <= '0;
         logged_state <= '0;
         slots_used <= '0;
         wr_todo <= '0;
         nvm_req_o <= 1'b0;
         nvm_addr_o <= '0;
         nvm_data_o <= '0;
      end else begin
         pending <= (pending & ~pick_oh) | new_log;
         case (log_state)
            LOG_IDLE: if (pick_valid) begin
               logged_state[pick_idx] <= 1'b1; // R7
               if (new_slot) slots_used <= slots_used + SLOT_W'(1);
               wr_todo <= {w_num, new_slot, w_state}; // R10
               if (w_num | new_slot | w_state) log_state <= LOG_WRITE;
            end
            LOG_WRITE: if (nvm_ack_i) begin
               wr_todo <= wr_todo & ~cur_bit;
               nvm_req_o <= 1'b0;
               if ((wr_todo & ~cur_bit) == 3'h0) log_state <= LOG_IDLE;
            end else begin
               nvm_req_o <= 1'b1;
               nvm_addr_o <= sel_addr;
               nvm_data_o <= sel_data;
            end
            default: log_state <= LOG_IDLE;
         endcase
      end
   end

   // checks
   sequence s_hw_take;
      hw_take;
   endsequence
   sequence s_halted_hold;
      (halt_o && lin_idle_o) [*4];
   endsequence
   a_enable_gates_detect: assert property ( // R1
      detect != '0 |-> (detect & ~$past(fault_enable_mask_i)) == '0)
      else $error("disabled fault was confirmed");
   a_flag_follows_status: assert property ( // R2
      fault_status != '0 |=> global_fault_flag_o || sensor_error_flag_o)
      else $error("fault present without frame flag");
   a_status_readback: assert property ( // R4
      reg_rd_i && reg_addr_i == FAULT_STATUS_OFFSET |=> reg_rdata_o == $past(fault_status))
      else $error("status readback mismatch");
   a_tick_spacing: assert property ( // R5
      tick |=> !tick [*2])
      else $error("check ticks too close");
   a_count_saturated: assert property ( // R9
      pick_valid && any_hit && hit_cnt == CNT_MAX && !w_state |=> wr_todo[2:1] == 2'b00)
      else $error("write issued for saturated fault");
   a_late_fault_once: assert property ( // R10
      pick_valid && !any_hit && !new_slot && logged_state[pick_idx] |=> log_state == LOG_IDLE)
      else $error("repeat of unslotted fault was written");
   a_hw_halts: assert property ( // R12
      s_hw_take |=> s_halted_hold)
      else $error("hardware fault did not halt and idle");
   a_fast_reboot: assert property ( // R14
      s_hw_take ##0 (fast_recovery_i && !log_busy && new_log == '0) |-> ##[1:3] reboot_o)
      else $error("fast recovery reboot late");
   a_self_check_arms: assert property ( // R15
      self_check_request_i |=> demand_arm)
      else $error("self check request not armed");
   a_slot_fixed: assert property ( // R18
      slots_used != '0 |=> slot_id[0] == $past(slot_id[0]))
      else $error("assigned log slot changed");
endmodule : fault_monitor_filter_logger

//--- tb/nvm_engine_model.sv
// nonvolatile write engine model: accepts each held write request once
// assumes requests stay up until accepted and come one at a time
`timescale 1ns/1ps
module nvm_engine_model (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // write handshake
   input wire logic req_i,
   input wire logic [1:0] lat_i, // wait cycles before accepting
   output logic ack_o
);
   logic [1:0] wait_cnt; // cycles spent on the current request
   // one-cycle accept pulse; wraps if lat_i moves under a running count
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_o <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (ack_o) begin // never accept one request twice
         ack_o <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (req_i) begin
         if (wait_cnt == lat_i) ack_o <= 1'b1;
         else wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule : nvm_engine_model

//--- tb/fault_monitor_filter_logger_tb.sv
// bench for the fault monitor: reads, debounce, log writes, hardware fault
// assumes shortened check and reboot periods; the engine model answers writes
`timescale 1ns/1ps
module fault_monitor_filter_logger_tb;
   import fault_monitor_pkg::*;
   localparam int CP = 20; // short check period keeps the run brief
   localparam logic [31:0] EN = 32'h0800_40A0; // faults 5, 7, 14, 27
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [31:0] fault_raw_i = 32'h0;
   logic [31:0] want = 32'h0; // enabled faults held present
   logic [3:0] thr = 4'h3; // debounce count
   logic hw_fault_i = 1'b0;
   logic fast = 1'b0; // recovery mode, fast when high
   logic [4:0] hw_idx = 5'h07; // bit index of the hardware fault
   logic self_check_request_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [1:0] lat = 2'h0; // engine accept latency
   logic nvm_ack_i, global_fault_flag_o, sensor_error_flag_o;
   logic lin_idle_o, halt_o, reboot_o, nvm_req_o;
   logic [31:0] reg_rdata_o, nvm_data_o;
   logic [5:0] nvm_addr_o;
   logic [31:0] rd_q[$]; // expected read data, oldest first
   logic [37:0] wr_q[$]; // expected address and data of log writes
   logic rd_prev = 1'b0; // a read was taken last cycle
   logic [31:0] seed = 32'd79950;
   int cyc = 0, mismatches = 0, num_checks = 0, n;

   always #50 core_clk_i = ~core_clk_i;

   fault_monitor_filter_logger #(.CHECK_PERIOD_CYCLES(CP), .REBOOT_PERIOD_CYCLES(10)) u_dut (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .fault_enable_mask_i(EN), .log_enable_mask_i(32'h0800_00A0),
      .consecutive_count_threshold_i(thr), .fast_recovery_i(fast),
      .fault_raw_i(fault_raw_i), .hw_fault_i(hw_fault_i), .hw_fault_index_i(hw_idx),
      .self_check_request_i(self_check_request_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
      .global_fault_flag_o(global_fault_flag_o), .sensor_error_flag_o(sensor_error_flag_o),
      .lin_idle_o(lin_idle_o), .halt_o(halt_o), .reboot_o(reboot_o),
      .nvm_req_o(nvm_req_o), .nvm_addr_o(nvm_addr_o), .nvm_data_o(nvm_data_o),
      .nvm_ack_i(nvm_ack_i));

   nvm_engine_model u_nvm (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .req_i(nvm_req_o), .lat_i(lat), .ack_o(nvm_ack_i));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk(string name, logic [37:0] exp, logic [37:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // new detector levels; disabled faults get noise that must never show
   task automatic put(logic [31:0] w);
      want = w;
      fault_raw_i = (xs() & ~EN) | want;
   endtask : put

   // wait for k mid-period points, far from any check tick
   task automatic mid(int k);
      repeat (k) begin
         do begin
            @(posedge core_clk_i);
            #1;
         end while (cyc < 21 || (cyc - 21) % CP != 10);
         put(want);
         lat = 2'(xs());
      end
   endtask : mid

   // one read strobe; the note goes to the queue first
   task automatic rd(logic [7:0] a, logic [31:0] exp);
      rd_q.push_back(exp);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      reg_rd_i = 1'b0;
      @(posedge core_clk_i);
      #1;
   endtask : rd

   // cycle count after reset and hang guard
   always @(posedge core_clk_i) begin
      if (!sys_rst_i) cyc <= cyc + 1;
      if (cyc > 3000) begin
         mismatches++;
         $display("[ERR] run timed out");
         end_of_test();
      end
   end

   // answers are compared on the falling edge, clear of register updates
   always @(negedge core_clk_i) begin
      if (rd_prev) begin
         if (rd_q.size() == 0) chk("spare read", 38'h0, 38'h1);
         else chk("reg_rdata_o", rd_q.pop_front(), reg_rdata_o);
      end
      rd_prev = reg_rd_i;
      if (nvm_req_o === 1'b1 && nvm_ack_i === 1'b1) begin
         if (wr_q.size() == 0) chk("spare write", 38'h0, {nvm_addr_o, nvm_data_o});
         else chk("nvm write", wr_q.pop_front(), {nvm_addr_o, nvm_data_o});
      end
   end

   initial begin
      repeat (16) @(posedge core_clk_i);
      #1;
      sys_rst_i = 1'b0;
      chk("halt_o", 1'b0, halt_o);
      rd(FAULT_STATUS_OFFSET, STATUS_RESET);
      rd(8'h10, 32'h0);
      mid(1);
      // two checks are one short of the count, a gap restarts it
      put(32'h20);
      mid(2);
      rd(8'hBC, 32'h0);
      put(32'h0);
      mid(1);
      put(32'h20);
      mid(2);
      rd(8'hBC, 32'h0);
      wr_q.push_back({NVM_ADDR_STATE, 32'h20});
      wr_q.push_back({NVM_ADDR_ID, 32'h06});
      wr_q.push_back({NVM_ADDR_NUM, 32'h01});
      mid(1);
      rd(8'hBC, 32'h20);
      chk("global_fault_flag_o", 1'b1, global_fault_flag_o);
      chk("sensor_error_flag_o", 1'b0, sensor_error_flag_o);
      put(32'h0);
      mid(1);
      rd(8'hBC, 32'h0);
      chk("global_fault_flag_o", 1'b0, global_fault_flag_o);
      // second sighting only bumps the count
      wr_q.push_back({NVM_ADDR_NUM, 32'h02});
      put(32'h20);
      mid(3);
      rd(8'hBC, 32'h20);
      put(32'h0);
      mid(1);
      // sensor class fault takes the second slot
      wr_q.push_back({NVM_ADDR_STATE, 32'h0800_0020});
      wr_q.push_back({NVM_ADDR_ID, 32'h0000_1C06});
      wr_q.push_back({NVM_ADDR_NUM, 32'h12});
      put(32'h0800_0000);
      mid(3);
      rd(8'hBC, 32'h0800_0000);
      chk("sensor_error_flag_o", 1'b1, sensor_error_flag_o);
      chk("global_fault_flag_o", 1'b0, global_fault_flag_o);
      put(32'h0);
      mid(1);
      // single-check debounce drives the count to its ceiling and past it
      thr = 4'h1;
      for (n = 3; n <= 16; n++) begin
         if (n <= 15) wr_q.push_back({NVM_ADDR_NUM, 32'h10 | n});
         put(32'h20);
         mid(1);
         put(32'h0);
         mid(1);
      end
      // startup-class fault stays unseen until a self check is asked for
      put(32'h4000);
      mid(2);
      rd(8'hBC, 32'h0);
      self_check_request_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      self_check_request_i = 1'b0;
      mid(1);
      rd(8'hBC, 32'h4000);
      put(32'h0);
      mid(1);
      // hardware fault halts, idles the link, logs, then reboots
      wr_q.push_back({NVM_ADDR_STATE, 32'h0800_00A0});
      wr_q.push_back({NVM_ADDR_ID, 32'h0008_1C06});
      wr_q.push_back({NVM_ADDR_NUM, 32'h11F});
      hw_fault_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      hw_fault_i = 1'b0;
      @(posedge core_clk_i);
      #1;
      chk("halt_o", 1'b1, halt_o);
      chk("lin_idle_o", 1'b1, lin_idle_o);
      n = 2;
      while (reboot_o !== 1'b1 && n < 400) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      chk("reboot_o", 1'b1, reboot_o);
      chk("reboot wait", 1'b1, n >= 10);
      rd(8'hBC, 32'h4080);
      chk("writes left", 38'h0, wr_q.size());
      // mid-run reset, then a fast-recovery hardware fault that is not logged
      sys_rst_i = 1'b1;
      fast = 1'b1;
      hw_idx = 5'h0E;
      repeat (2) @(posedge core_clk_i);
      #1;
      sys_rst_i = 1'b0;
      chk("halt_o", 1'b0, halt_o);
      chk("reboot_o", 1'b0, reboot_o);
      rd(8'hBC, 32'h0);
      hw_fault_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      hw_fault_i = 1'b0;
      chk("halt_o", 1'b1, halt_o);
      chk("reboot_o", 1'b0, reboot_o);
      @(posedge core_clk_i);
      #1;
      chk("reboot_o", 1'b1, reboot_o);
      rd(8'hBC, 32'h4000);
      end_of_test();
   end
endmodule : fault_monitor_filter_logger_tb
